// ===== hdl/icoc_pkg.sv
`default_nettype none
package icoc_pkg;
   // Register indices; the byte address on the register port is four times the index.
   localparam logic [7:0] IDX_LCD_START = 8'h71;
   localparam logic [7:0] IDX_LCD_THR = 8'h7E;
   localparam logic [7:0] IDX_TV_START = 8'h81;
   localparam logic [7:0] IDX_TV_C0_B = 8'h86;
   localparam logic [7:0] IDX_TV_C0_G = 8'h87;
   localparam logic [7:0] IDX_TV_C0_R = 8'h88;
   localparam logic [7:0] IDX_TV_C1_B = 8'h8A;
   localparam logic [7:0] IDX_TV_C1_G = 8'h8B;
   localparam logic [7:0] IDX_TV_C1_R = 8'h8C;
   localparam logic [7:0] IDX_TV_THR = 8'h8E;
   localparam logic [7:0] IDX_CTRL = 8'h90;
   localparam logic [7:0] IDX_DISP_W_LO = 8'h91;
   localparam logic [7:0] IDX_DISP_W_HI = 8'h92;
   localparam logic [7:0] IDX_DISP_H_LO = 8'h93;
   localparam logic [7:0] IDX_DISP_H_HI = 8'h94;
   localparam logic [7:0] IDX_PANEL_W_LO = 8'h95;
   localparam logic [7:0] IDX_PANEL_W_HI = 8'h96;
   localparam logic [7:0] IDX_PANEL_H_LO = 8'h97;
   localparam logic [7:0] IDX_PANEL_H_HI = 8'h98;
   localparam logic [7:0] IDX_STATUS = 8'h99;
   localparam int REG_ADDR_W = 10;
   // Control register bit positions.
   localparam int CTRL_LCD_INK = 0;
   localparam int CTRL_TV_INK = 1;
   localparam int CTRL_COLOR_PANEL = 2;
   localparam int CTRL_LCD_EN = 3;
   localparam int CTRL_TV_EN = 4;
   localparam int CTRL_W = 5;
   localparam int STAT_W = 2;
   // Geometry of the overlay images in the display buffer.
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam int DIM_W = 11;
   localparam int THR_W = 4;
   localparam logic [ADDR_W-1:0] CURSOR_BYTES = 22'h000400;
   localparam int BLOCK_SHIFT = 13;
   localparam int INK_SHIFT = 2;
   localparam int DUAL_SHIFT = 4;
   localparam int COLOR_FACTOR_SHIFT = 2;
   localparam logic [THR_W-1:0] AUTO_THRESH = 4'h8;
   typedef enum logic [1:0] {
      OVL_COLOR0 = 2'b00,
      OVL_COLOR1 = 2'b01,
      OVL_BG = 2'b10,
      OVL_INV_BG = 2'b11
   } icoc_code_type;
   typedef struct packed {
      logic [4:0] red;
      logic [5:0] green;
      logic [4:0] blue;
   } icoc_rgb_type;
   typedef struct packed {
      logic valid;
      logic [ADDR_W-1:0] addr;
   } icoc_mem_req_type;
endpackage
`default_nettype wire

// ===== hdl/icoc_overlay_fetch.sv
`timescale 1ns/1ns
`default_nettype none
module icoc_overlay_fetch import icoc_pkg::*; #(
   parameter int DEPTH = 16,
   parameter int WORD_W = DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic frame_start,
   input wire logic [ADDR_W-1:0] base,
   input wire logic [ADDR_W-1:0] length,
   input wire logic [THR_W-1:0] threshold,
   output icoc_mem_req_type mem,
   input wire logic mem_valid,
   input wire logic [WORD_W-1:0] mem_data,
   input wire logic pop,
   output icoc_code_type code,
   output logic code_valid,
   output logic underrun
);
   localparam int LW = $clog2(DEPTH + 1);
   localparam int PW = $clog2(DEPTH);
   localparam int SW = $clog2(WORD_W / 2);
   localparam logic [ADDR_W-1:0] STEP = ADDR_W'(WORD_W / 8);

   // The threshold field can ask for up to fifteen words, so the store must hold them.
   if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0 || WORD_W != DATA_W) begin : g_bad_depth
      $error("icoc_overlay_fetch: DEPTH must be a power of two of at least 16, WORD_W must be DATA_W.");
   end

   typedef enum logic {FETCH_IDLE = 1'b0, FETCH_WAIT = 1'b1} icoc_fetch_state_type;
   icoc_fetch_state_type state;
   logic [WORD_W-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr, rd_ptr;
   logic [LW-1:0] level;
   logic [SW-1:0] sub;
   logic [ADDR_W-1:0] addr, remain;
   logic stale;
   logic [THR_W-1:0] thr_eff;
   logic issue, push, word_done;

   // A zero field hands the choice of threshold back to the hardware.
   assign thr_eff = (threshold == '0) ? AUTO_THRESH : threshold;
   // One read is in flight at a time, so the fill never passes the threshold.
   assign issue = state == FETCH_IDLE && enable && !frame_start && remain != '0 && level < LW'(thr_eff);
   assign push = mem_valid && state == FETCH_WAIT && !stale && !frame_start;
   assign word_done = pop && level != '0 && sub == SW'(WORD_W / 2 - 1);
   assign code_valid = level != '0;
   assign code = icoc_code_type'(store[rd_ptr][{sub, 1'b0} +: 2]);

   // Read state; a frame start never cancels a read already on the memory port.
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= FETCH_IDLE;
      end else begin
         unique case (state)
            FETCH_IDLE: if (issue) state <= FETCH_WAIT;
            FETCH_WAIT: if (mem_valid) state <= FETCH_IDLE;
         endcase
      end
   end

   // Data for a read issued before the frame start is thrown away when it arrives.
   always_ff @(posedge clk) begin
      if (rst) begin
         stale <= 1'b0;
      end else if (frame_start) begin
         stale <= state == FETCH_WAIT && !mem_valid;
      end else if (mem_valid) begin
         stale <= 1'b0;
      end
   end

   // The image is walked in order from its start address each frame.
   always_ff @(posedge clk) begin
      if (rst) begin
         addr <= '0;
         remain <= '0;
         mem <= '0;
      end else begin
         mem.valid <= issue;
         if (frame_start) begin
            addr <= base;
            remain <= length;
         end else if (issue) begin
            mem.addr <= addr;
            addr <= addr + STEP;
            remain <= (remain < STEP) ? '0 : remain - STEP;
         end
      end
   end

   // Word store; the frame start flushes it so that no stale pixels leak into a frame.
   always_ff @(posedge clk) begin
      if (rst || frame_start) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (word_done) rd_ptr <= rd_ptr + 1'b1;
         level <= level + LW'(push) - LW'(word_done);
      end
   end

   always_ff @(posedge clk) begin
      if (push) store[wr_ptr] <= mem_data;
   end

   // Pixel index within the head word, and the underrun pulse for a pull on an empty store.
   always_ff @(posedge clk) begin
      if (rst || frame_start) begin
         sub <= '0;
         underrun <= 1'b0;
      end else begin
         underrun <= pop && level == '0;
         if (pop && level != '0) sub <= sub + 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   auto_threshold_a: assert property (threshold == '0 |-> thr_eff == AUTO_THRESH)
      else $error("Zero threshold did not select the automatic value.");
   fill_bound_a: assert property (mem.valid |-> $past(level) < LW'($past(thr_eff)))
      else $error("Overlay read issued with the store at or above its threshold.");
   sequence frame_kick_s;
      frame_start && enable && length != '0 && state == FETCH_IDLE ##1 !frame_start && enable;
   endsequence
   first_read_a: assert property (frame_kick_s |=> mem.valid && mem.addr == $past(base, 2))
      else $error("First overlay read did not start at the computed address.");
endmodule // icoc_overlay_fetch
`default_nettype wire

// ===== hdl/icoc_ink_cursor_overlay_config.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - TV colour 0 is a 5-6-5 value in three byte registers, upper bits zero.
// - TV colour 1 uses the same 5-6-5 layout in its own three registers.
// - The low four bits of one register set the LCD overlay fetch threshold.
// - A second register of the same layout sets the TV overlay fetch threshold.
// - A threshold of zero makes the hardware pick the threshold itself.
// - The threshold limits the overlay store fill; a pull on an empty store sets an underrun flag.
// - Each display path has its own start address register in the buffer.
// - Dual panel buffer size is width times height times factor over sixteen.
// - The dual panel buffer starts at memory size minus its own size.
// - A cursor image is always exactly 1024 bytes.
// - An ink layer is width times height over four bytes.
// - Codes pick colour 0, colour 1, background or inverted background.
// - Start value zero means size minus 1024; n means size minus n times 8192.
module icoc_ink_cursor_overlay_config import icoc_pkg::*; #(
   parameter int MEM_BYTES = 2097152,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [REG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [1:0] frame_start,
   output icoc_mem_req_type [1:0] mem_req,
   input wire logic [1:0] mem_valid,
   input wire logic [1:0][DATA_W-1:0] mem_data,
   input wire logic [1:0] pix_pop,
   output logic [1:0] pix_valid,
   output icoc_code_type [1:0] pix_code,
   input wire icoc_rgb_type tv_bg,
   output icoc_rgb_type tv_pix_colour,
   output logic [ADDR_W-1:0] dual_base
);
   localparam logic [ADDR_W-1:0] MEM_SIZE = ADDR_W'(MEM_BYTES);

   // The largest start code must still land inside the buffer.
   if (MEM_BYTES < (255 << BLOCK_SHIFT) || MEM_BYTES >= (1 << ADDR_W)) begin : g_bad_mem
      $error("icoc_ink_cursor_overlay_config: MEM_BYTES out of the range the address logic serves.");
   end

   logic [7:0] lcd_start, tv_start;
   logic [THR_W-1:0] lcd_thr, tv_thr;
   icoc_rgb_type tv_c0, tv_c1;
   logic [CTRL_W-1:0] ctrl;
   logic [DIM_W-1:0] disp_w, disp_h, panel_w, panel_h;
   logic [STAT_W-1:0] status;
   logic [7:0] idx;
   logic aligned, wr_hit, rd_hit;
   logic [7:0] next_rdata;
   logic [1:0][7:0] start_code;
   logic [1:0][THR_W-1:0] path_thr;
   logic [1:0][ADDR_W-1:0] base, length;
   logic [1:0] ink_mode, path_en, underrun;
   logic [1:0] code_valid;
   icoc_code_type [1:0] code;
   logic [ADDR_W-1:0] ink_bytes, dual_size, panel_area;
   icoc_rgb_type next_colour;

   // Registers sit one to a word; a byte address that is not word aligned decodes to nothing.
   assign idx = reg_addr[REG_ADDR_W-1:2];
   assign aligned = reg_addr[1:0] == 2'b00;
   assign wr_hit = reg_wr && aligned;
   assign rd_hit = reg_rd && aligned;

   // Start address codes, one per path.
   always_ff @(posedge clk) begin
      if (rst) begin
         lcd_start <= '0;
         tv_start <= '0;
      end else if (wr_hit) begin
         if (idx == IDX_LCD_START) lcd_start <= reg_wdata;
         if (idx == IDX_TV_START) tv_start <= reg_wdata;
      end
   end

   // Fetch thresholds keep only the low nibble; the upper bits are not stored.
   always_ff @(posedge clk) begin
      if (rst) begin
         lcd_thr <= '0;
         tv_thr <= '0;
      end else if (wr_hit) begin
         if (idx == IDX_LCD_THR) lcd_thr <= reg_wdata[THR_W-1:0];
         if (idx == IDX_TV_THR) tv_thr <= reg_wdata[THR_W-1:0];
      end
   end

   // TV overlay colours in 5-6-5 form.
   always_ff @(posedge clk) begin
      if (rst) begin
         tv_c0 <= '0;
         tv_c1 <= '0;
      end else if (wr_hit) begin
         unique case (idx)
            IDX_TV_C0_B: tv_c0.blue <= reg_wdata[4:0];
            IDX_TV_C0_G: tv_c0.green <= reg_wdata[5:0];
            IDX_TV_C0_R: tv_c0.red <= reg_wdata[4:0];
            IDX_TV_C1_B: tv_c1.blue <= reg_wdata[4:0];
            IDX_TV_C1_G: tv_c1.green <= reg_wdata[5:0];
            IDX_TV_C1_R: tv_c1.red <= reg_wdata[4:0];
            default: ;
         endcase
      end
   end

   // Mode, enables and the display and panel dimensions.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= '0;
         disp_w <= '0;
         disp_h <= '0;
         panel_w <= '0;
         panel_h <= '0;
      end else if (wr_hit) begin
         unique case (idx)
            IDX_CTRL: ctrl <= reg_wdata[CTRL_W-1:0];
            IDX_DISP_W_LO: disp_w[7:0] <= reg_wdata;
            IDX_DISP_W_HI: disp_w[DIM_W-1:8] <= reg_wdata[DIM_W-9:0];
            IDX_DISP_H_LO: disp_h[7:0] <= reg_wdata;
            IDX_DISP_H_HI: disp_h[DIM_W-1:8] <= reg_wdata[DIM_W-9:0];
            IDX_PANEL_W_LO: panel_w[7:0] <= reg_wdata;
            IDX_PANEL_W_HI: panel_w[DIM_W-1:8] <= reg_wdata[DIM_W-9:0];
            IDX_PANEL_H_LO: panel_h[7:0] <= reg_wdata;
            IDX_PANEL_H_HI: panel_h[DIM_W-1:8] <= reg_wdata[DIM_W-9:0];
            default: ;
         endcase
      end
   end

   // Sticky underrun flags, cleared by writing one; a new underrun wins over the clear.
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= (status & ~((wr_hit && idx == IDX_STATUS) ? reg_wdata[STAT_W-1:0] : '0)) | underrun;
      end
   end

   // Readback; unmapped or unaligned addresses read as zero.
   always_comb begin
      next_rdata = '0;
      unique case (idx)
         IDX_LCD_START: next_rdata = lcd_start;
         IDX_TV_START: next_rdata = tv_start;
         IDX_LCD_THR: next_rdata = {4'h0, lcd_thr};
         IDX_TV_THR: next_rdata = {4'h0, tv_thr};
         IDX_TV_C0_B: next_rdata = {3'h0, tv_c0.blue};
         IDX_TV_C0_G: next_rdata = {2'h0, tv_c0.green};
         IDX_TV_C0_R: next_rdata = {3'h0, tv_c0.red};
         IDX_TV_C1_B: next_rdata = {3'h0, tv_c1.blue};
         IDX_TV_C1_G: next_rdata = {2'h0, tv_c1.green};
         IDX_TV_C1_R: next_rdata = {3'h0, tv_c1.red};
         IDX_CTRL: next_rdata = {3'h0, ctrl};
         IDX_DISP_W_LO: next_rdata = disp_w[7:0];
         IDX_DISP_W_HI: next_rdata = {5'h00, disp_w[DIM_W-1:8]};
         IDX_DISP_H_LO: next_rdata = disp_h[7:0];
         IDX_DISP_H_HI: next_rdata = {5'h00, disp_h[DIM_W-1:8]};
         IDX_PANEL_W_LO: next_rdata = panel_w[7:0];
         IDX_PANEL_W_HI: next_rdata = {5'h00, panel_w[DIM_W-1:8]};
         IDX_PANEL_H_LO: next_rdata = panel_h[7:0];
         IDX_PANEL_H_HI: next_rdata = {5'h00, panel_h[DIM_W-1:8]};
         IDX_STATUS: next_rdata = {6'h00, status};
         default: next_rdata = '0;
      endcase
      if (!aligned) next_rdata = '0;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (rd_hit || reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // Image sizes: the ink layer is two bits per display pixel, the cursor a fixed block.
   assign ink_bytes = ADDR_W'(({11'h000, disp_w} * {11'h000, disp_h}) >> INK_SHIFT);
   assign panel_area = ADDR_W'({11'h000, panel_w} * {11'h000, panel_h});
   // Colour panels need four times the monochrome space.
   assign dual_size = (ctrl[CTRL_COLOR_PANEL] ? (panel_area << COLOR_FACTOR_SHIFT) : panel_area) >> DUAL_SHIFT;

   // The dual panel buffer is pinned to the very top of memory.
   always_ff @(posedge clk) begin
      if (rst) begin
         dual_base <= MEM_SIZE;
      end else begin
         dual_base <= MEM_SIZE - dual_size;
      end
   end

   assign start_code[0] = lcd_start;
   assign start_code[1] = tv_start;
   assign path_thr[0] = lcd_thr;
   assign path_thr[1] = tv_thr;
   assign ink_mode = {ctrl[CTRL_TV_INK], ctrl[CTRL_LCD_INK]};
   assign path_en = {ctrl[CTRL_TV_EN], ctrl[CTRL_LCD_EN]};

   // One fetch engine per display path, each with its own placement and threshold.
   for (genvar p = 0; p < 2; p++) begin : g_path
      // Overlapping placements are software's concern; the hardware does not check them.
      assign base[p] = (start_code[p] == '0) ? MEM_SIZE - CURSOR_BYTES
                     : MEM_SIZE - (ADDR_W'(start_code[p]) << BLOCK_SHIFT);
      assign length[p] = ink_mode[p] ? ink_bytes : CURSOR_BYTES;

      icoc_overlay_fetch #(
         .DEPTH(DEPTH),
         .WORD_W(DATA_W)
      ) u_fetch (
         .clk(clk),
         .rst(rst),
         .enable(path_en[p]),
         .frame_start(frame_start[p]),
         .base(base[p]),
         .length(length[p]),
         .threshold(path_thr[p]),
         .mem(mem_req[p]),
         .mem_valid(mem_valid[p]),
         .mem_data(mem_data[p]),
         .pop(pix_pop[p]),
         .code(code[p]),
         .code_valid(code_valid[p]),
         .underrun(underrun[p])
      );

      // The pixel code is handed out one cycle after the pull.
      always_ff @(posedge clk) begin
         if (rst) begin
            pix_valid[p] <= 1'b0;
            pix_code[p] <= OVL_BG;
         end else begin
            pix_valid[p] <= pix_pop[p] && code_valid[p];
            if (pix_pop[p] && code_valid[p]) pix_code[p] <= code[p];
         end
      end
   end

   // TV colour selection; the LCD colours live elsewhere, so that path hands out the code only.
   always_comb begin
      next_colour = tv_bg; // An unwritten store word at startup would otherwise match no item.
      case (code[1])
         OVL_COLOR0: next_colour = tv_c0;
         OVL_COLOR1: next_colour = tv_c1;
         OVL_BG: next_colour = tv_bg;
         OVL_INV_BG: next_colour = ~tv_bg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tv_pix_colour <= '0;
      end else if (pix_pop[1] && code_valid[1]) begin
         tv_pix_colour <= next_colour;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Last written byte, kept so that the steering checks can compare against it.
   logic [7:0] wd_hold;
   always_ff @(posedge clk) begin
      if (reg_wr) wd_hold <= reg_wdata;
   end

   color0_upper_a: assert property (rd_hit && idx == IDX_TV_C0_B |=> reg_rdata[7:5] == 3'h0)
      else $error("Colour 0 blue read back with upper bits set.");
   sequence c1_green_wr_rd_s;
      wr_hit && idx == IDX_TV_C1_G ##1 rd_hit && idx == IDX_TV_C1_G && !reg_wr;
   endsequence
   color1_green_a: assert property (c1_green_wr_rd_s |=> reg_rdata == {2'h0, wd_hold[5:0]})
      else $error("Colour 1 green read back differs from the written field.");
   lcd_thr_upper_a: assert property (rd_hit && idx == IDX_LCD_THR |=> reg_rdata[7:4] == 4'h0)
      else $error("LCD threshold read back with upper bits set.");
   tv_thr_steer_a: assert property (wr_hit && idx == IDX_TV_THR |=> path_thr[1] == wd_hold[3:0])
      else $error("TV threshold write did not reach the TV fetch.");
   start_zero_a: assert property (lcd_start == '0 |-> base[0] == MEM_SIZE - CURSOR_BYTES)
      else $error("Start code zero did not place the overlay 1024 bytes below the top.");
   start_block_a: assert property (tv_start != '0 |-> base[1] + (ADDR_W'(tv_start) << BLOCK_SHIFT) == MEM_SIZE)
      else $error("TV start code did not place the overlay in 8192 byte steps.");
   dual_top_a: assert property (##1 dual_base + $past(dual_size) == MEM_SIZE)
      else $error("Dual panel buffer does not end at the top of memory.");
   cursor_size_a: assert property (!ink_mode[0] |-> length[0] == CURSOR_BYTES)
      else $error("Cursor image length is not 1024 bytes.");
   inv_bg_a: assert property (pix_pop[1] && code_valid[1] && code[1] == OVL_INV_BG |=> tv_pix_colour == ~$past(tv_bg))
      else $error("Inverted background code did not show the inverted background.");
   // LCD threshold, colour 0 red and colour 1 blue writes must land in their fields; unaligned reads give zero and underruns set status.
   lcd_thr_steer_a: assert property (wr_hit && idx == IDX_LCD_THR |=> path_thr[0] == wd_hold[3:0])
      else $error("LCD threshold write did not reach the LCD fetch.");
   color0_red_a: assert property (wr_hit && idx == IDX_TV_C0_R |=> tv_c0.red == wd_hold[4:0])
      else $error("Colour 0 red write did not land in its field.");
   color1_blue_a: assert property (wr_hit && idx == IDX_TV_C1_B |=> tv_c1.blue == wd_hold[4:0])
      else $error("Colour 1 blue write did not land in its field.");
   unaligned_read_a: assert property (reg_rd && !aligned |=> reg_rdata == 8'h00)
      else $error("Unaligned read returned nonzero data.");
   tv_underrun_a: assert property (underrun[1] |=> status[1])
      else $error("TV underrun was not recorded in the status flag.");
   lcd_underrun_a: assert property (underrun[0] |=> status[0])
      else $error("LCD underrun was not recorded in the status flag.");
endmodule // icoc_ink_cursor_overlay_config
`default_nettype wire

// ===== sim/tb_ink_cursor_overlay_config.sv
`timescale 1ns/1ns
`default_nettype none
module tb_ink_cursor_overlay_config import icoc_pkg::*;;
   localparam int MEM = 2097152;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [REG_ADDR_W-1:0] reg_addr = '0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [1:0] frame_start = 2'b00;
   icoc_mem_req_type [1:0] mem_req;
   logic [1:0] mem_valid = 2'b00;
   logic [1:0][DATA_W-1:0] mem_data = '0;
   logic [1:0] pix_pop = 2'b00;
   logic [1:0] pix_valid;
   icoc_code_type [1:0] pix_code;
   icoc_rgb_type tv_bg = 16'h1234;
   icoc_rgb_type tv_pix_colour;
   logic [ADDR_W-1:0] dual_base;
   int mismatches = 0;
   int tests_run = 0;
   int req_cnt [2];
   logic [ADDR_W-1:0] first_addr [2];
   logic [ADDR_W-1:0] last_addr [2];
   logic [7:0] idx_tab [10] = '{8'h7E, 8'h86, 8'h87, 8'h88, 8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h71, 8'h81};
   logic [7:0] mask_tab [10] = '{8'h0F, 8'h1F, 8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h1F, 8'h0F, 8'hFF, 8'hFF};

   icoc_ink_cursor_overlay_config #(.MEM_BYTES(MEM), .DEPTH(16)) dut (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start), .mem_req(mem_req),
      .mem_valid(mem_valid), .mem_data(mem_data), .pix_pop(pix_pop), .pix_valid(pix_valid),
      .pix_code(pix_code), .tv_bg(tv_bg), .tv_pix_colour(tv_pix_colour), .dual_base(dual_base));

   // The clock toggles every half period of 5 ns.
   always #5 clk = ~clk;

   // Memory answers each read one cycle later; the word holds pixel codes 0,1,2,3 repeated.
   always @(posedge clk) begin
      for (int p = 0; p < 2; p++) begin
         mem_valid[p] <= mem_req[p].valid;
         mem_data[p] <= 16'hE4E4;
         if (mem_req[p].valid === 1'b1) begin
            if (req_cnt[p] == 0) first_addr[p] = mem_req[p].addr;
            last_addr[p] = mem_req[p].addr;
            req_cnt[p] = req_cnt[p] + 1;
         end
      end
   end

   // Compares one observed value against its expectation.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] data);
      @(posedge clk);
      reg_addr <= {idx, 2'b00};
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Read data are sampled in the single cycle after the strobe.
   task automatic rd(input logic [REG_ADDR_W-1:0] addr, output logic [7:0] data);
      @(posedge clk);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 data = reg_rdata;
   endtask

   task automatic frame(input int p);
      @(posedge clk);
      frame_start[p] <= 1'b1;
      req_cnt[p] = 0;
      @(posedge clk);
      frame_start[p] <= 1'b0;
   endtask

   // Runs n cycles with the display either pulling a pixel every cycle or idle.
   task automatic run(input int p, input int n, input logic pop);
      repeat (n) begin
         @(posedge clk);
         pix_pop[p] <= pop;
      end
      @(posedge clk);
      pix_pop <= 2'b00;
   endtask

   task automatic pop_chk(input icoc_code_type code, input icoc_rgb_type colour);
      @(posedge clk);
      pix_pop[1] <= 1'b1;
      @(posedge clk);
      pix_pop[1] <= 1'b0;
      #1;
      check(pix_valid[1], 1'b1);
      check(pix_code[1], code);
      check(tv_pix_colour, colour);
   endtask

   task automatic conclude();
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hang short well after the roughly seven thousand cycles the tests need.
   initial begin
      repeat (50000) @(posedge clk);
      mismatches++;
      conclude();
   end

   initial begin
      logic [7:0] d;
      req_cnt = '{0, 0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Each threshold, colour and start register starts at zero and keeps only its documented bits.
      for (int i = 0; i < 10; i++) begin
         rd({idx_tab[i], 2'b00}, d);
         check(d, 8'h00);
         wr(idx_tab[i], 8'hFF);
         rd({idx_tab[i], 2'b00}, d);
         check(d, mask_tab[i]);
      end
      // Write and read of colour 1 green with no idle cycle between the strobes.
      @(posedge clk);
      reg_addr <= {IDX_TV_C1_G, 2'b00};
      reg_wdata <= 8'hEB;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, 8'h2B);
      rd(10'h140, d);
      check(d, 8'h00);
      rd({IDX_TV_THR, 2'b01}, d);
      check(d, 8'h00);
      // Dual panel buffer sits at the top of memory for colour and monochrome panels.
      wr(IDX_PANEL_W_LO, 8'h20);
      wr(IDX_PANEL_H_LO, 8'h10);
      wr(IDX_CTRL, 8'(1 << CTRL_COLOR_PANEL));
      repeat (3) @(posedge clk);
      check(dual_base, MEM - 32 * 16 * 4 / 16);
      wr(IDX_CTRL, 8'h00);
      repeat (3) @(posedge clk);
      check(dual_base, MEM - 32 * 16 / 16);
      // No dual panel buffer is kept from here on, so the overlays below cannot overlap it.
      wr(IDX_PANEL_W_LO, 8'h00);
      repeat (3) @(posedge clk);
      check(dual_base, MEM);
      // TV cursor with a programmed threshold of three words and no pixels pulled.
      wr(IDX_TV_C0_B, 8'h05);
      wr(IDX_TV_C0_G, 8'h2A);
      wr(IDX_TV_C0_R, 8'h11);
      wr(IDX_TV_C1_B, 8'h1A);
      wr(IDX_TV_C1_G, 8'h15);
      wr(IDX_TV_C1_R, 8'h0E);
      wr(IDX_TV_THR, 8'h03);
      wr(IDX_TV_START, 8'h00);
      wr(IDX_CTRL, 8'(1 << CTRL_TV_EN));
      frame(1);
      run(1, 100, 1'b0);
      check(req_cnt[1], 3);
      check(first_addr[1], MEM - 1024);
      // A zero threshold falls back to the automatic depth; the restart flushes the store.
      // Writing the threshold after the restart keeps a read of the old walk from being counted.
      frame(1);
      wr(IDX_TV_THR, 8'h00);
      run(1, 100, 1'b0);
      check(req_cnt[1], AUTO_THRESH);
      pop_chk(OVL_COLOR0, {5'h11, 6'h2A, 5'h05});
      pop_chk(OVL_COLOR1, {5'h0E, 6'h15, 5'h1A});
      pop_chk(OVL_BG, 16'h1234);
      pop_chk(OVL_INV_BG, ~16'h1234);
      // Draining the whole cursor reads exactly 1024 bytes in ascending order.
      run(1, 6000, 1'b1);
      check(req_cnt[1], 512);
      check(last_addr[1], MEM - 2);
      rd({IDX_STATUS, 2'b00}, d);
      check(d, 8'h02);
      wr(IDX_STATUS, 8'h02);
      rd({IDX_STATUS, 2'b00}, d);
      check(d, 8'h00);
      // LCD ink layer of 16 by 8 pixels in the second 8 KiB block from the top.
      wr(IDX_DISP_W_LO, 8'h10);
      wr(IDX_DISP_H_LO, 8'h08);
      wr(IDX_LCD_START, 8'h02);
      wr(IDX_CTRL, 8'(1 << CTRL_LCD_EN | 1 << CTRL_LCD_INK));
      frame(0);
      // The first ink pixel is code 0 and comes out one cycle after its pull.
      repeat (10) @(posedge clk);
      pix_pop[0] <= 1'b1;
      @(posedge clk);
      pix_pop[0] <= 1'b0;
      #1 check({pix_valid[0], pix_code[0]}, {1'b1, OVL_COLOR0});
      run(0, 600, 1'b1);
      check(req_cnt[0], 16 * 8 / 4 / 2);
      check(first_addr[0], MEM - 2 * 8192);
      check(last_addr[0], MEM - 2 * 8192 + 30);
      conclude();
   end
endmodule // tb_ink_cursor_overlay_config
`default_nettype wire
